/* File: hw/vme_sizer_pkg.sv */
// ********************************************************************
// Shared constants and types of the transfer sizer
// ********************************************************************
`default_nettype none
package vme_sizer_pkg;

	// ****************************************************************
	// Register byte offsets, one aligned word each
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_AM = 8'h04;
	localparam logic [7:0] OFS_THROTTLE = 8'h08;
	localparam logic [7:0] OFS_SELECT = 8'h0C;
	localparam logic [7:0] OFS_ADDR = 8'h10;
	localparam logic [7:0] OFS_LENGTH = 8'h14;
	localparam logic [7:0] OFS_GO = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_WIDE_BIT = 0;
	localparam int CTRL_CSWAP_BIT = 1;
	localparam int SEL_ODD_BIT = 3;
	localparam int GO_START_BIT = 0;
	localparam int STATUS_BUSY_BIT = 31;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic CTRL_WIDE_RST = 1'b0;
	localparam logic CTRL_CSWAP_RST = 1'b0;
	localparam logic [5:0] AM_RST = 6'h00;
	localparam logic [3:0] THROTTLE_RST = 4'hB;
	localparam logic [7:0] SELECT_RST = 8'h03;

	// ****************************************************************
	// Throttle, burst caps and cycle widths in bytes
	// ****************************************************************
	localparam logic [7:0] THROTTLE_MAX = 8'h0B;
	localparam logic [11:0] BURST_D64_CAP = 12'h800;
	localparam logic [11:0] BURST_BLK_CAP = 12'h100;
	localparam logic [11:0] BURST_NB_CAP = 12'h800;
	localparam logic [11:0] BURST_MIN = 12'h002;
	localparam logic [3:0] W16 = 4'h2;
	localparam logic [3:0] W32 = 4'h4;
	localparam logic [3:0] W64 = 4'h8;

	// ****************************************************************
	// Address modifier codes
	// ****************************************************************
	localparam logic [5:0] AM_D64_A = 6'h08;
	localparam logic [5:0] AM_D64_B = 6'h0C;
	localparam logic [5:0] AM_D64_C = 6'h38;
	localparam logic [5:0] AM_D64_D = 6'h3C;
	localparam logic [5:0] AM_BLT_A = 6'h0B;
	localparam logic [5:0] AM_BLT_B = 6'h0F;
	localparam logic [5:0] AM_BLT_C = 6'h3B;
	localparam logic [5:0] AM_BLT_D = 6'h3F;

	// Cycle descriptor: first flag, byte count, address
	localparam int DESC_W = 37;

	// Sequencer states, one-hot
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;

	// Whole state of the sizer
	typedef struct packed
	{
		seq_state_t state;
		logic wide;
		logic cswap;
		logic [5:0] am;
		logic [3:0] throttle;
		logic [7:0] select;
		logic [31:0] addr;
		logic [23:0] remain;
		logic [11:0] burst_left;
		logic [31:0] rd_data;
		logic [31:0] ctl_word;
		logic ctl_valid;
	} sizer_state_t;

endpackage
`default_nettype wire

/* File: hw/sizer_skid_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Two-entry buffer with registered outputs
// ********************************************************************
module sizer_skid_buffer
#(
	parameter int WIDTH = vme_sizer_pkg::DESC_W
)
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Filling side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Draining side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);

	// Output stage plus one spill entry
	typedef struct packed
	{
		logic out_valid;
		logic skid_valid;
		logic in_ready;
		logic [WIDTH-1:0] out_data;
		logic [WIDTH-1:0] skid_data;
	} buf_state_t;

	buf_state_t st;
	buf_state_t next_st;

	// Next state: drain first, then fill
	always_comb
	begin
		next_st = st;
		if (st.out_valid && i_out_ready)
		begin
			// Spill entry moves up, else stage empties
			if (st.skid_valid)
			begin
				next_st.out_data = st.skid_data;
				next_st.skid_valid = 1'b0;
			end
			else
			begin
				next_st.out_valid = 1'b0;
			end
		end
		if (i_in_valid && st.in_ready)
		begin
			if (!next_st.out_valid)
			begin
				next_st.out_valid = 1'b1;
				next_st.out_data = i_in_data;
			end
			else
			begin
				next_st.skid_valid = 1'b1;
				next_st.skid_data = i_in_data;
			end
		end
		// Ready is registered, so full means spill entry taken
		next_st.in_ready = !next_st.skid_valid;
		if (!i_rst_n)
		begin
			next_st = '0;
			next_st.in_ready = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk)
	begin
		st <= next_st;
	end

	assign o_in_ready = st.in_ready;
	assign o_out_valid = st.out_valid;
	assign o_out_data = st.out_data;

	// Word held while stalled
	hold_stall_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		st.out_valid && !i_out_ready |=> st.out_valid && $stable(st.out_data))
		else $error("buffered word changed under stall");

endmodule
`default_nettype wire

/* File: hw/vme_transfer_sizer.sv */
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Width select clear forces 16-bit cycles
// - Width select set: 32 or 64 by modifier
// - Modifiers 08,0C,38,3C give 64-bit cycles
// - Narrow cycles until aligned, then widest allowed
// - Misaligned buffer: align burst, then throttle bursts
// - Throttle is log2 of burst bytes
// - Throttle above 0B is clamped to 0B
// - Throttle written by options, read back
// - D64 block: 2048 only on 2K boundary
// - Other block modes cap bursts at 256
// - Non-block modes allow up to 2048
// - Control words swapped, payload never swapped
// - Select flag bit 3 ignored, reads zero
module vme_transfer_sizer
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// Cycle descriptors towards the bus master
	output logic o_cyc_valid,
	output logic [31:0] o_cyc_addr,
	output logic [3:0] o_cyc_bytes,
	output logic o_cyc_first,
	input wire logic i_cyc_ready,
	// Control structure words
	input wire logic i_ctl_valid,
	input wire logic [31:0] i_ctl_word,
	output logic o_ctl_valid,
	output logic [31:0] o_ctl_word,
	// Engine state
	output logic o_busy
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// Modifier selects D64 block transfers
	function automatic logic is_d64(input logic [5:0] am);
		return (am == vme_sizer_pkg::AM_D64_A) ||
			(am == vme_sizer_pkg::AM_D64_B) ||
			(am == vme_sizer_pkg::AM_D64_C) ||
			(am == vme_sizer_pkg::AM_D64_D);
	endfunction

	// Modifier selects a non-D64 block transfer
	function automatic logic is_blt(input logic [5:0] am);
		return (am == vme_sizer_pkg::AM_BLT_A) ||
			(am == vme_sizer_pkg::AM_BLT_B) ||
			(am == vme_sizer_pkg::AM_BLT_C) ||
			(am == vme_sizer_pkg::AM_BLT_D);
	endfunction

	// Widest cycle the control bit and modifier permit
	function automatic logic [3:0] max_width(input logic wide,
		input logic [5:0] am);
		if (!wide)
			return vme_sizer_pkg::W16;
		else if (is_d64(am))
			return vme_sizer_pkg::W64;
		else
			return vme_sizer_pkg::W32;
	endfunction

	// Cycle width from alignment, what is left and the budget
	function automatic logic [3:0] pick_width(input logic [2:0] a,
		input logic [3:0] maxw, input logic [23:0] rem,
		input logic [11:0] left);
		logic [3:0] w;
		w = vme_sizer_pkg::W16;
		if (maxw != vme_sizer_pkg::W16 && a[1] == 1'b0 &&
			rem >= 24'h000004 && left >= 12'h004)
			w = vme_sizer_pkg::W32;
		if (maxw == vme_sizer_pkg::W64 && a == 3'h0 &&
			rem >= 24'h000008 && left >= 12'h008)
			w = vme_sizer_pkg::W64;
		return w;
	endfunction

	// Byte order reversal for control words
	function automatic logic [31:0] swap_bytes(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	// ****************************************************************
	// State and internal signals
	// ****************************************************************
	vme_sizer_pkg::sizer_state_t st;
	vme_sizer_pkg::sizer_state_t next_st;

	// Buffer handshake
	logic buf_ready;
	logic push;
	logic push_first;
	logic [3:0] push_bytes;
	// Burst budget for the cycle now being sized
	logic [11:0] left_now;
	logic [11:0] new_burst;
	logic [11:0] burst_cap;
	logic [11:0] thr_len;
	logic [3:0] maxw;

	// ****************************************************************
	// Burst budget
	// ****************************************************************

	// Length of a burst that would start at the current address
	always_comb
	begin
		maxw = max_width(st.wide, st.am);
		thr_len = 12'h001 << st.throttle;
		// D64 gets 2K only on a 2K boundary
		if (is_d64(st.am))
			burst_cap = (st.addr[10:0] == 11'h000) ?
				vme_sizer_pkg::BURST_D64_CAP :
				vme_sizer_pkg::BURST_BLK_CAP;
		else if (is_blt(st.am))
			burst_cap = vme_sizer_pkg::BURST_BLK_CAP;
		else
			burst_cap = vme_sizer_pkg::BURST_NB_CAP;
		// first move only up to double-longword alignment
		if (st.addr[2:0] != 3'h0)
			new_burst = {9'h000, 3'h0 - st.addr[2:0]};
		else if (thr_len < burst_cap)
			new_burst = thr_len;
		else
			new_burst = burst_cap;
		// Word cycles cannot be split, so never below two bytes
		if (new_burst < vme_sizer_pkg::BURST_MIN)
			new_burst = vme_sizer_pkg::BURST_MIN;
		push_first = (st.burst_left == 12'h000);
		left_now = push_first ? new_burst : st.burst_left;
		push_bytes = pick_width(st.addr[2:0], maxw, st.remain, left_now);
		push = (st.state == vme_sizer_pkg::ST_RUN) && buf_ready;
	end

	// ****************************************************************
	// Register port and sequencer
	// ****************************************************************

	// Next state of registers and engine
	always_comb
	begin
		next_st = st;
		// Read data stand for one cycle only
		next_st.rd_data = 32'h00000000;
		next_st.ctl_valid = 1'b0;
		// swap applies to control words, never to payload
		if (i_ctl_valid)
		begin
			next_st.ctl_valid = 1'b1;
			next_st.ctl_word = st.cswap ? swap_bytes(i_ctl_word) : i_ctl_word;
		end
		// Register reads; unmapped offsets return zero
		if (i_reg_rd)
		begin
			case (i_reg_addr)
				vme_sizer_pkg::OFS_CTRL:
					next_st.rd_data = {30'h00000000, st.cswap, st.wide};
				vme_sizer_pkg::OFS_AM:
					next_st.rd_data = {26'h0000000, st.am};
				vme_sizer_pkg::OFS_THROTTLE:
					next_st.rd_data = {28'h0000000, st.throttle};
				vme_sizer_pkg::OFS_SELECT:
					next_st.rd_data = {24'h000000, st.select};
				vme_sizer_pkg::OFS_ADDR:
					next_st.rd_data = st.addr;
				vme_sizer_pkg::OFS_LENGTH:
					next_st.rd_data = {8'h00, st.remain};
				vme_sizer_pkg::OFS_STATUS:
					next_st.rd_data = {st.state == vme_sizer_pkg::ST_RUN,
						7'h00, st.remain};
				default:
					next_st.rd_data = 32'h00000000;
			endcase
		end
		// Register writes; setup is locked while a transfer runs
		if (i_reg_wr && st.state == vme_sizer_pkg::ST_IDLE)
		begin
			case (i_reg_addr)
				// data swap bits are not stored
				vme_sizer_pkg::OFS_CTRL:
				begin
					next_st.wide = i_reg_wdata[vme_sizer_pkg::CTRL_WIDE_BIT];
					next_st.cswap = i_reg_wdata[vme_sizer_pkg::CTRL_CSWAP_BIT];
				end
				vme_sizer_pkg::OFS_AM:
					next_st.am = i_reg_wdata[5:0];
				vme_sizer_pkg::OFS_THROTTLE:
					next_st.throttle =
						(i_reg_wdata[7:0] > vme_sizer_pkg::THROTTLE_MAX) ?
						vme_sizer_pkg::THROTTLE_MAX[3:0] : i_reg_wdata[3:0];
				vme_sizer_pkg::OFS_SELECT:
				begin
					next_st.select = i_reg_wdata[7:0];
					next_st.select[vme_sizer_pkg::SEL_ODD_BIT] = 1'b0;
				end
				// bit 0 forced low, odd addresses unsupported
				vme_sizer_pkg::OFS_ADDR:
					next_st.addr = {i_reg_wdata[31:1], 1'b0};
				// Lengths are whole words as well
				vme_sizer_pkg::OFS_LENGTH:
					next_st.remain = {i_reg_wdata[23:1], 1'b0};
				// Start only with something to move
				vme_sizer_pkg::OFS_GO:
					if (i_reg_wdata[vme_sizer_pkg::GO_START_BIT] &&
						st.remain != 24'h000000)
					begin
						next_st.state = vme_sizer_pkg::ST_RUN;
						next_st.burst_left = 12'h000;
					end
				default:
					next_st.state = st.state;
			endcase
		end
		// Sequencer: one cycle descriptor per accepted slot
		case (st.state)
			vme_sizer_pkg::ST_IDLE:
				next_st.burst_left = next_st.burst_left;
			vme_sizer_pkg::ST_RUN:
				if (push)
				begin
					// budget counts down across one burst
					next_st.addr = st.addr + {28'h0000000, push_bytes};
					next_st.remain = st.remain - {20'h00000, push_bytes};
					next_st.burst_left = left_now - {8'h00, push_bytes};
					if (st.remain == {20'h00000, push_bytes})
					begin
						next_st.state = vme_sizer_pkg::ST_IDLE;
						next_st.burst_left = 12'h000;
					end
				end
			default:
				next_st.state = vme_sizer_pkg::ST_IDLE;
		endcase
		// Synchronous reset to defaults
		if (!i_rst_n)
		begin
			next_st = '0;
			next_st.state = vme_sizer_pkg::ST_IDLE;
			next_st.wide = vme_sizer_pkg::CTRL_WIDE_RST;
			next_st.cswap = vme_sizer_pkg::CTRL_CSWAP_RST;
			next_st.am = vme_sizer_pkg::AM_RST;
			next_st.throttle = vme_sizer_pkg::THROTTLE_RST;
			next_st.select = vme_sizer_pkg::SELECT_RST;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk)
	begin
		st <= next_st;
	end

	// ****************************************************************
	// Descriptor buffer
	// ****************************************************************

	// A stalled bus master holds the sequencer, nothing is lost
	sizer_skid_buffer #(
		.WIDTH(vme_sizer_pkg::DESC_W)
	) u_buf (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_in_valid(push),
		.i_in_data({push_first, push_bytes, st.addr}),
		.o_in_ready(buf_ready),
		.o_out_valid(o_cyc_valid),
		.o_out_data({o_cyc_first, o_cyc_bytes, o_cyc_addr}),
		.i_out_ready(i_cyc_ready)
	);

	// Registered outputs
	assign o_reg_rdata = st.rd_data;
	assign o_ctl_valid = st.ctl_valid;
	assign o_ctl_word = st.ctl_word;
	assign o_busy = (st.state == vme_sizer_pkg::ST_RUN);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_burst_start;
		push && push_first;
	endsequence

	sequence s_thr_big;
		i_reg_wr && i_reg_addr == vme_sizer_pkg::OFS_THROTTLE &&
			st.state == vme_sizer_pkg::ST_IDLE && i_reg_wdata[7:0] > 8'h0B;
	endsequence

	narrow_cycle_a: assert property (push && !st.wide |-> push_bytes == 4'h2)
		else $error("narrow mode issued a wide cycle");
	wide_cycle_a: assert property (push && st.wide && st.addr[1:0] == 2'h0 &&
		st.remain >= 24'h000004 && left_now >= 12'h004 |-> push_bytes != 4'h2)
		else $error("wide mode stayed at 16 bits");
	d64_cycle_a: assert property (push && st.wide && is_d64(st.am) &&
		st.addr[2:0] == 3'h0 && st.remain >= 24'h000008 &&
		left_now >= 12'h008 |-> push_bytes == 4'h8)
		else $error("D64 modifier missed a 64 bit cycle");
	cycle_align_a: assert property (push |->
		(st.addr[3:0] & (push_bytes - 4'h1)) == 4'h0)
		else $error("cycle not aligned to its width");
	align_burst_a: assert property (s_burst_start and st.addr[2:0] != 3'h0
		|-> left_now == {9'h000, 3'h0 - st.addr[2:0]})
		else $error("first burst overshoots alignment");
	throttle_clamp_a: assert property (s_thr_big |=> st.throttle == 4'hB)
		else $error("oversize throttle not clamped");
	burst_cap_a: assert property (s_burst_start and st.addr[2:0] == 3'h0 |->
		left_now <= burst_cap && left_now <= thr_len ||
		left_now == 12'h002)
		else $error("burst above throttle or mode cap");
	blt_cap_a: assert property (s_burst_start and is_blt(st.am) |->
		left_now <= 12'h100)
		else $error("block burst above 256 bytes");
	d64_cap_a: assert property (s_burst_start and is_d64(st.am) &&
		st.addr[10:0] != 11'h000 |-> left_now <= 12'h100)
		else $error("unaligned D64 burst above 256 bytes");
	odd_flag_a: assert property (i_reg_rd && i_reg_addr ==
		vme_sizer_pkg::OFS_SELECT |=> o_reg_rdata[3] == 1'b0)
		else $error("select bit 3 read as one");
	swap_ctl_a: assert property (i_ctl_valid && st.cswap |=>
		o_ctl_word == swap_bytes($past(i_ctl_word)))
		else $error("control word not swapped");

endmodule
`default_nettype wire

/* File: tb/vme_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bus master side: takes cycle descriptors and logs them
// ****************************************************************
module vme_sink_model
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Descriptor stream
	input wire logic i_cyc_valid,
	input wire logic [31:0] i_cyc_addr,
	input wire logic [3:0] i_cyc_bytes,
	input wire logic i_cyc_first,
	output logic o_cyc_ready,
	// Stall pattern select
	input wire logic i_slow
);
	// Log of taken descriptors, read by the bench
	logic [31:0] log_addr [0:2047];
	logic [3:0] log_bytes [0:2047];
	logic log_first [0:2047];
	// Number of descriptors taken so far
	int count = 0;
	// Stall phase counter
	logic [1:0] phase = 2'h0;

	// Slow mode takes one word in four, so the buffer fills up
	assign o_cyc_ready = !i_slow || (phase == 2'h3);

	// Log each descriptor at the edge where it is taken
	always @(posedge i_sys_clk)
	begin
		phase <= phase + 2'h1;
		if (i_rst_n && i_cyc_valid && o_cyc_ready && count < 2048)
		begin
			log_addr[count] <= i_cyc_addr;
			log_bytes[count] <= i_cyc_bytes;
			log_first[count] <= i_cyc_first;
			count <= count + 1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/test_vme_transfer_sizer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_vme_transfer_sizer;
	// ************************************************************
	// Stimulus and observed signals
	// ************************************************************
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [31:0] i_reg_wdata = 32'h00000000;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic i_ctl_valid = 1'b0;
	logic [31:0] i_ctl_word = 32'h00000000;
	logic slow = 1'b0; // Sink stall mode
	logic [31:0] o_reg_rdata;
	logic o_cyc_valid;
	logic [31:0] o_cyc_addr;
	logic [3:0] o_cyc_bytes;
	logic o_cyc_first;
	logic cyc_ready;
	logic o_ctl_valid;
	logic [31:0] o_ctl_word;
	logic o_busy;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0; // Hang guard
	logic [5:0] d64_codes [0:3] = '{6'h08, 6'h0C, 6'h38, 6'h3C};

	vme_transfer_sizer i_dut
	(
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .o_cyc_valid(o_cyc_valid),
		.o_cyc_addr(o_cyc_addr), .o_cyc_bytes(o_cyc_bytes),
		.o_cyc_first(o_cyc_first), .i_cyc_ready(cyc_ready),
		.i_ctl_valid(i_ctl_valid), .i_ctl_word(i_ctl_word),
		.o_ctl_valid(o_ctl_valid), .o_ctl_word(o_ctl_word),
		.o_busy(o_busy)
	);

	vme_sink_model i_sink
	(
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_cyc_valid(o_cyc_valid), .i_cyc_addr(o_cyc_addr),
		.i_cyc_bytes(o_cyc_bytes), .i_cyc_first(o_cyc_first),
		.o_cyc_ready(cyc_ready), .i_slow(slow)
	);

	// 200 MHz clock
	always #2.5 i_sys_clk = ~i_sys_clk;

	// Cut a hang short well above the expected run length
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			conclude();
		end
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic conclude();
		$display("Checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle write; the trailing edge keeps strobes apart
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_sys_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
		#1;
		d = o_reg_rdata;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	// Reset values, in-range throttle write, read-only zero bit, unmapped place
	task automatic regs();
		logic [31:0] v;
		rd(vme_sizer_pkg::OFS_THROTTLE, v);
		check(v, 32'h0000000B);
		rd(vme_sizer_pkg::OFS_SELECT, v);
		check(v, 32'h00000003);
		rd(vme_sizer_pkg::OFS_CTRL, v);
		check(v, 32'h00000000);
		rd(8'h20, v);
		check(v, 32'h00000000);
		wr(vme_sizer_pkg::OFS_SELECT, 32'h000000FF);
		rd(vme_sizer_pkg::OFS_SELECT, v);
		check(v, 32'h000000F7);
		wr(vme_sizer_pkg::OFS_THROTTLE, 32'h00000007);
		rd(vme_sizer_pkg::OFS_THROTTLE, v);
		check(v, 32'h00000007);
	endtask

	// Control words, back to back, both swapped or both plain by sw
	task automatic ctl(input logic sw);
		logic [31:0] a;
		logic [31:0] b;
		a = 32'h11223344;
		b = 32'hA1B2C3D4;
		wr(vme_sizer_pkg::OFS_CTRL, {30'h0, sw, 1'b0});
		@(posedge i_sys_clk);
		i_ctl_valid <= 1'b1;
		i_ctl_word <= a;
		@(posedge i_sys_clk);
		i_ctl_word <= b;
		#1;
		check({31'h0, o_ctl_valid}, 32'h00000001);
		check(o_ctl_word, sw ? {a[7:0], a[15:8], a[23:16], a[31:24]} : a);
		@(posedge i_sys_clk);
		i_ctl_valid <= 1'b0;
		#1;
		check(o_ctl_word, sw ? {b[7:0], b[15:8], b[23:16], b[31:24]} : b);
		@(posedge i_sys_clk);
		#1;
		check({31'h0, o_ctl_valid}, 32'h00000000);
	endtask

	// Program a transfer, run it and compare every cycle taken
	task automatic run(input logic wide, input logic [5:0] am,
		input logic [7:0] thr, input logic [31:0] addr,
		input logic [23:0] len, input logic slw);
		int a;
		int n;
		int t;
		int left;
		int bud;
		int cap;
		int w;
		int i;
		int base;
		logic fst;
		logic d64;
		logic blt;
		logic [31:0] v;
		logic [31:0] ea [$];
		logic [3:0] eb [$];
		logic ef [$];
		// Host keeps data swap bits clear and gives even addresses
		// host duties
		wr(vme_sizer_pkg::OFS_CTRL, {31'h0, wide});
		wr(vme_sizer_pkg::OFS_AM, {26'h0, am});
		wr(vme_sizer_pkg::OFS_THROTTLE, {24'h0, thr});
		wr(vme_sizer_pkg::OFS_ADDR, addr);
		wr(vme_sizer_pkg::OFS_LENGTH, {8'h0, len});
		t = (thr > 8'h0B) ? 11 : int'(thr);
		rd(vme_sizer_pkg::OFS_THROTTLE, v);
		check(v, 32'(t));
		d64 = (am == 6'h08 || am == 6'h0C || am == 6'h38 || am == 6'h3C);
		blt = (am == 6'h0B || am == 6'h0F || am == 6'h3B || am == 6'h3F);
		a = int'(addr);
		n = int'(len);
		left = 0;
		// Expected cycles: alignment burst first, then capped bursts
		while (n > 0)
		begin
			fst = (left == 0);
			if (fst)
			begin
				if (a % 8 != 0)
					bud = 8 - a % 8;
				else
				begin
					bud = 1 << t;
					cap = d64 ? ((a % 2048 == 0) ? 2048 : 256) : (blt ? 256 : 2048);
					if (bud > cap)
						bud = cap;
					if (bud < 2)
						bud = 2;
				end
				left = bud;
			end
			w = !wide ? 2 : (d64 ? 8 : 4);
			while (w > 2 && (a % w != 0 || w > n || w > left))
				w = w / 2;
			ea.push_back(32'(a));
			eb.push_back(4'(w));
			ef.push_back(fst);
			a += w;
			n -= w;
			left -= w;
		end
		base = i_sink.count;
		slow <= slw;
		wr(vme_sizer_pkg::OFS_GO, 32'h00000001);
		// Stalled sink keeps the engine running while status is read
		if (slw)
		begin
			rd(vme_sizer_pkg::OFS_STATUS, v);
			check({31'h0, v[31]}, 32'h00000001);
		end
		i = 0;
		while ((o_busy !== 1'b0 || o_cyc_valid !== 1'b0 || i < 4) && i < 20000)
		begin
			@(posedge i_sys_clk);
			// Look once outputs have settled after the edge
			#1;
			i++;
		end
		slow <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		#1;
		// Engine must have stopped on its own, not by the guard
		check(32'(i < 20000), 32'h00000001);
		check({31'h0, o_busy}, 32'h00000000);
		check(32'(i_sink.count - base), 32'(ea.size()));
		for (i = 0; i < ea.size() && base + i < 2048; i++)
		begin
			check(i_sink.log_addr[base + i], ea[i]);
			check({28'h0, i_sink.log_bytes[base + i]}, {28'h0, eb[i]});
			check({31'h0, i_sink.log_first[base + i]}, {31'h0, ef[i]});
		end
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		regs();
		ctl(1'b1);
		ctl(1'b0);
		run(1'b0, 6'h08, 8'h0B, 32'h1002, 24'h10, 1'b0);
		run(1'b1, 6'h08, 8'h0B, 32'h1002, 24'h10, 1'b0);
		for (int k = 0; k < 4; k++)
			run(1'b1, d64_codes[k], 8'h0B, 32'h800, 24'h18, 1'b0);
		run(1'b1, 6'h09, 8'h02, 32'h0, 24'h20, 1'b0);
		run(1'b1, 6'h09, 8'h00, 32'h6, 24'h0C, 1'b0);
		run(1'b1, 6'h08, 8'h0C, 32'h800, 24'h900, 1'b1);
		run(1'b1, 6'h0C, 8'h0B, 32'h808, 24'h110, 1'b0);
		run(1'b1, 6'h0B, 8'hFF, 32'h0, 24'h110, 1'b1);
		run(1'b1, 6'h09, 8'h0B, 32'h0, 24'h810, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
